// File: rtl/plm_pkg.sv
package plm_pkg;
   // Port geometry
   localparam int PORT_WIDTH = 8;
   // Output latch reset value
   localparam logic [7:0] LATCH_RST = 8'h00;
   // Idle levels that the peripheral controls take at reset
   localparam logic SER_LEVEL_RST = 1'b1;
   localparam logic TMR_LEVEL_RST = 1'b0;
   localparam logic OUT_EN_RST = 1'b0;
   localparam logic I2C_EN_RST = 1'b0;
   localparam logic BUZ_EN_RST = 1'b0;
   localparam logic REDIR_RST = 1'b0;
   // Tie-offs for absent functions
   localparam logic SER_TIE = 1'b1;
   localparam logic OTHER_TIE = 1'b0;
   localparam logic OD_TIE = 1'b0;
   // Read-modify-write operations
   typedef enum logic [1:0] {PLM_OP_AND, PLM_OP_OR, PLM_OP_XOR, PLM_OP_NOT} plm_op_e;
endpackage

// File: rtl/plm_pin_mux.sv
`timescale 1ns/10ps
// One pin's output gating: latch AND serial, OR other peripherals.
module plm_pin_mux (
   // Sources
   input  wire logic latch_in,
   input  wire logic serial_in,
   input  wire logic other_in,
   // Control
   input  wire logic dir_out_in,
   input  wire logic digital_in,
   input  wire logic open_drain_in,
   // Pin drive
   output logic      pin_data_out,
   output logic      pin_oe_n_out
);
   logic level;

   // Combine the three sources
   always_comb begin
      level = (latch_in & serial_in) | other_in;
   end

   // Buffer enable; open drain only drives low
   always_comb begin
      pin_data_out = open_drain_in ? 1'b0 : level;
      if (dir_out_in && digital_in && !(open_drain_in && level)) begin
         pin_oe_n_out = 1'b0;
      end else begin
         pin_oe_n_out = 1'b1;
      end
   end
endmodule // plm_pin_mux

// File: rtl/plm_port.sv
`timescale 1ns/10ps
// Contract
// - Output mode: write loads latch and latch drives pin.
// - Latch holds until next write in either mode.
// - Reset clears every latch bit.
// - Input mode write updates latch, pin stays undriven.
// - Output mode read returns latch value.
// - Input mode read returns pin level.
// - Plain read leaves latch unchanged.
// - Output mode RMW: operand from latch, result to latch and pin.
// - Input mode RMW: operand from pin, result to latch only.
// - Pin = (latch AND serial) OR other peripheral outputs.
// - Missing open-drain select acts as 0.
// - Missing serial function ties 1; missing other function ties 0.
// - Redirection moves peripheral output to alternative pin.
// - Reset leaves all peripheral outputs in disabled idle state; plm_port does not gate them on reset, their enables come straight from inputs.
module plm_port
   import plm_pkg::*;
#(
   parameter int WIDTH = plm_pkg::PORT_WIDTH,
   parameter logic [7:0] HAS_OD = 8'hff,
   parameter logic [7:0] HAS_SER = 8'hff,
   parameter logic [7:0] HAS_OTHER = 8'hff,
   parameter logic [7:0] HAS_ANALOG = 8'h0f
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // Processor access
   input  wire logic             wr_en_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             rd_en_in,
   input  wire logic             rmw_en_in,
   input  wire plm_pkg::plm_op_e rmw_op_in,
   input  wire logic [WIDTH-1:0] rmw_arg_in,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   // Pin configuration
   input  wire logic [WIDTH-1:0] dir_out_in,
   input  wire logic [WIDTH-1:0] analog_sel_in,
   input  wire logic [WIDTH-1:0] open_drain_select_in,
   input  wire logic [WIDTH-1:0] redirect_in,
   // Serial array unit controls
   input  wire logic [WIDTH-1:0] serial_data_raw_in,
   input  wire logic [WIDTH-1:0] serial_output_enable_in,
   // Other peripheral outputs (timer, clock/buzzer, i2c)
   input  wire logic [WIDTH-1:0] timer_channel_output_in,
   input  wire logic [WIDTH-1:0] timer_output_enable_in,
   input  wire logic [WIDTH-1:0] i2c_line_raw_in,
   input  wire logic             i2c_operation_enable_in,
   input  wire logic [WIDTH-1:0] clock_buzzer_raw_in,
   input  wire logic             clock_buzzer_output_enable_in,
   // Pins
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe_n_out
);
   import plm_pkg::*;

   logic [WIDTH-1:0] latch_q, latch_d;
   logic [WIDTH-1:0] rd_data_q, rd_data_d;
   logic             rd_valid_q, rd_valid_d;
   logic [WIDTH-1:0] pin_s1_q, pin_s2_q;
   logic [WIDTH-1:0] digital, od_eff, ser_eff, other_eff, other_moved, view;

   // Apply the selected read-modify-write operation
   function automatic logic [WIDTH-1:0] apply_op(input plm_op_e op, input logic [WIDTH-1:0] a,
                                                 input logic [WIDTH-1:0] b);
      case (op)
         PLM_OP_AND: apply_op = a & b;
         PLM_OP_OR:  apply_op = a | b;
         PLM_OP_XOR: apply_op = a ^ b;
         default:    apply_op = ~a;
      endcase
   endfunction

   // Pin synchroniser
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Per-bit view: latch for outputs, pin level for inputs
   always_comb begin
      view = (dir_out_in & latch_q) | (~dir_out_in & pin_s2_q);
   end

   // Latch and read port next values
   always_comb begin
      latch_d    = latch_q;
      rd_data_d  = rd_data_q;
      rd_valid_d = 1'b0;
      if (rmw_en_in) begin
         latch_d = apply_op(rmw_op_in, view, rmw_arg_in);
      end else if (wr_en_in) begin
         latch_d = wr_data_in;
      end
      if (rd_en_in) begin
         rd_data_d  = view;
         rd_valid_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         latch_q    <= LATCH_RST;
         rd_data_q  <= '0;
         rd_valid_q <= 1'b0;
      end else begin
         latch_q    <= latch_d;
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   assign rd_data_out  = rd_data_q;
   assign rd_valid_out = rd_valid_q;

   // Source gating and tie-offs for absent functions
   always_comb begin
      digital = ~(analog_sel_in & HAS_ANALOG);
      od_eff  = open_drain_select_in & HAS_OD;
      ser_eff = (serial_data_raw_in | ~serial_output_enable_in) | ~HAS_SER;
      other_eff = (timer_channel_output_in & timer_output_enable_in)
                | (i2c_line_raw_in & {WIDTH{i2c_operation_enable_in}})
                | (clock_buzzer_raw_in & {WIDTH{clock_buzzer_output_enable_in}});
      // Redirected bits move one pin up, freeing the original pin
      other_moved = ((other_eff & ~redirect_in) | ({other_eff[WIDTH-2:0], 1'b0}
                    & {redirect_in[WIDTH-2:0], 1'b0})) & HAS_OTHER;
   end

   // Per-pin output circuit
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      plm_pin_mux u_mux (
         .latch_in      (latch_q[i]),
         .serial_in     (ser_eff[i]),
         .other_in      (other_moved[i]),
         .dir_out_in    (dir_out_in[i]),
         .digital_in    (digital[i]),
         .open_drain_in (od_eff[i]),
         .pin_data_out  (pin_out[i]),
         .pin_oe_n_out  (pin_oe_n_out[i])
      );
   end
endmodule // plm_port

// File: test/plm_port_properties.sv
`timescale 1ns/10ps
// Read path and pin enable checks
module plm_port_properties
   import plm_pkg::*;
(
   input wire logic             clk_in,
   input wire logic             rst_n_in,
   input wire logic             wr_en_in,
   input wire logic [7:0]       wr_data_in,
   input wire logic             rd_en_in,
   input wire logic             rmw_en_in,
   input wire plm_pkg::plm_op_e rmw_op_in,
   input wire logic [7:0]       rmw_arg_in,
   input wire logic [7:0]       dir_out_in,
   input wire logic [7:0]       analog_sel_in,
   input wire logic [7:0]       pin_in,
   input wire logic [7:0]       rd_data_out,
   input wire logic             rd_valid_out,
   input wire logic [7:0]       pin_oe_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_rst; disable iff (1'b0) !rst_n_in |=> rd_data_out == 8'h00 && !rd_valid_out; endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   property p_wrrd; (wr_en_in && !rmw_en_in && dir_out_in == 8'hff) ##1 (rd_en_in && !wr_en_in && !rmw_en_in
      && dir_out_in == 8'hff) |=> rd_data_out == $past(wr_data_in, 2); endproperty
   a_wrrd: assert property (p_wrrd) else $error("read after write wrong");
   property p_valid; 1 |=> rd_valid_out == $past(rd_en_in); endproperty
   a_valid: assert property (p_valid) else $error("read strobe wrong");
   property p_hold; !rd_en_in |=> $stable(rd_data_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_in; 1 |-> (pin_oe_n_out | dir_out_in) == 8'hff; endproperty
   a_in: assert property (p_in) else $error("input bit driven");
   property p_ana; 1 |-> (analog_sel_in & 8'h0f & ~pin_oe_n_out) == 8'h00; endproperty
   a_ana: assert property (p_ana) else $error("analog bit driven");
   property p_pin; (dir_out_in == 8'h00 && $stable(pin_in))[*3] ##0 rd_en_in |=> rd_data_out == $past(pin_in);
   endproperty
   a_pin: assert property (p_pin) else $error("input read wrong");
   property p_rmw; (wr_en_in && !rmw_en_in && dir_out_in == 8'hff) ##1 (rmw_en_in && rmw_op_in == PLM_OP_XOR
      && dir_out_in == 8'hff) ##1 (rd_en_in && !wr_en_in && !rmw_en_in)
      |=> rd_data_out == ($past(wr_data_in, 3) ^ $past(rmw_arg_in, 2)); endproperty
   a_rmw: assert property (p_rmw) else $error("xor result wrong");
endmodule // plm_port_properties

// File: test/plm_pin_env.sv
`timescale 1ns/10ps
// Outside circuit: released pins follow an external source
module plm_pin_env (
   input  wire logic [7:0] pin_out_in,
   input  wire logic [7:0] pin_oe_n_in,
   input  wire logic [7:0] ext_level_in,
   output logic      [7:0] pin_level_out
);
   assign pin_level_out = (pin_out_in & ~pin_oe_n_in) | (ext_level_in & pin_oe_n_in);
endmodule // plm_pin_env

// File: test/plm_port_tb.sv
`timescale 1ns/10ps
// Bench for the port latch and pin gating
module plm_port_tb;
   import plm_pkg::*;
   logic clk_in, rst_n_in, wr_en, rd_en, rmw_en, i2c_en, buz_en, rd_valid;
   logic [7:0] wr_data, rmw_arg, dir, ana, ser_raw, ser_oe, tmr, tmr_oe, i2c_raw, buz_raw, ext, pin_lvl, rd_data, pin_o, oe_n;
   logic [7:0] od, redir;
   plm_op_e op;
   int n_fail, n_checks, n_cyc;
   logic [7:0] exp_tab [4] = '{8'h14, 8'hbe, 8'haa, 8'hc3};
   plm_port i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en), .wr_data_in(wr_data), .rd_en_in(rd_en),
      .rmw_en_in(rmw_en), .rmw_op_in(op), .rmw_arg_in(rmw_arg), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .dir_out_in(dir), .analog_sel_in(ana), .open_drain_select_in(od), .redirect_in(redir),
      .serial_data_raw_in(ser_raw), .serial_output_enable_in(ser_oe), .timer_channel_output_in(tmr),
      .timer_output_enable_in(tmr_oe), .i2c_line_raw_in(i2c_raw), .i2c_operation_enable_in(i2c_en),
      .clock_buzzer_raw_in(buz_raw), .clock_buzzer_output_enable_in(buz_en), .pin_in(pin_lvl), .pin_out(pin_o),
      .pin_oe_n_out(oe_n));
   plm_pin_env i_env (.pin_out_in(pin_o), .pin_oe_n_in(oe_n), .ext_level_in(ext), .pin_level_out(pin_lvl));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      wr_en = 1;
      wr_data = d;
      tick(1);
      wr_en = 0;
   endtask
   task automatic rmw(input plm_op_e o, input logic [7:0] a);
      rmw_en = 1;
      op = o;
      rmw_arg = a;
      tick(1);
      rmw_en = 0;
   endtask
   task automatic rd(input logic [7:0] e);
      rd_en = 1;
      tick(1);
      rd_en = 0;
      chk("rd_valid", 8'h01, {7'h00, rd_valid});
      chk("rd_data", e, rd_data);
   endtask
   // Clock and hang guard
   initial begin
      clk_in = 0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      n_cyc++;
      if (n_cyc > 2000) begin
         n_fail++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      {wr_en, rd_en, rmw_en, i2c_en, buz_en} = '0;
      {wr_data, rmw_arg, ana, ser_raw, ser_oe, tmr, tmr_oe, buz_raw, ext} = '0;
      {od, redir} = '0;
      i2c_raw = 8'h80;
      op = PLM_OP_AND;
      dir = 8'hff;
      rst_n_in = 0;
      tick(3);
      rst_n_in = 1;
      rd(8'h00);
      chk("pin_out", 8'h00, pin_o);
      wr(8'ha5);
      rd(8'ha5);
      chk("pin_out", 8'ha5, pin_o);
      dir = 8'h00;
      ext = 8'h3c;
      wr(8'h5a);
      chk("pin_oe_n", 8'hff, oe_n);
      tick(2);
      rd(8'h3c);
      dir = 8'hff;
      rd(8'h5a);
      for (int i = 0; i < 4; i++) begin
         wr(8'h3c);
         rmw(plm_op_e'(i), 8'h96);
         rd(exp_tab[i]);
         chk("pin_out", exp_tab[i], pin_o);
      end
      dir = 8'h00;
      ext = 8'hf0;
      tick(3);
      rmw(PLM_OP_OR, 8'h0f);
      chk("pin_oe_n", 8'hff, oe_n);
      dir = 8'hff;
      rd(8'hff);
      wr(8'h0f);
      {ser_oe, tmr_oe, tmr, buz_raw, buz_en} = {8'h01, 8'h20, 8'h30, 8'h40, 1'b1};
      tick(1);
      chk("pin_out", 8'h6e, pin_o);
      ana = 8'h11;
      tick(1);
      chk("pin_oe_n", 8'h01, oe_n);
      ana = 8'h00;
      redir = 8'h20;
      tick(1);
      chk("pin_out", 8'h4e, pin_o);
      od = 8'h02;
      tick(1);
      chk("pin_out", 8'h4c, pin_o);
      chk("pin_oe_n", 8'h02, oe_n);
      final_report();
   end
endmodule // plm_port_tb
bind plm_port plm_port_properties i_chk (.*);
